//--- rtl/ifs_pkg.sv
// Package: register map, field layout and framing constants for the fault status bank.
// Assumes a Modbus RTU slave on RS-485 with a 20 MHz system clock.
`default_nettype none
package ifs_pkg;
   // Register indices (protocol address)
   localparam logic [15:0] IFS_REG_DET_STATE  = 16'h0000;
   localparam logic [15:0] IFS_REG_CHAN_COUNT = 16'h0001;
   localparam logic [15:0] IFS_REG_MAX_FAULT  = 16'h0002;
   localparam logic [15:0] IFS_REG_NET_FORM   = 16'h0003;
   localparam logic [15:0] IFS_REG_CH1_STATUS = 16'h0004;
   localparam logic [15:0] IFS_REG_CH8_STATUS = 16'h000B;
   localparam logic [15:0] IFS_REG_EVENT_MEM  = 16'h000C;
   localparam logic [15:0] IFS_REG_LAST       = 16'h000C;

   localparam logic [15:0] IFS_CHAN4_CODE = 16'h0004;
   localparam logic [15:0] IFS_CHAN8_CODE = 16'h0008;

   localparam logic [1:0] IFS_NET_DC   = 2'h0;
   localparam logic [1:0] IFS_NET_AC   = 2'h1;
   localparam logic [1:0] IFS_NET_3AC  = 2'h2;

   localparam logic [7:0] IFS_ST_NONE    = 8'h00;
   localparam logic [7:0] IFS_ST_CONN    = 8'h01;
   localparam logic [7:0] IFS_ST_PREWARN = 8'h02;
   localparam logic [7:0] IFS_ST_ALARM   = 8'h04;
   localparam logic [7:0] IFS_ST_SHORT   = 8'h10;
   localparam logic [7:0] IFS_ST_UNKNOWN = 8'h20;
   localparam logic [7:0] IFS_CUR_INVALID = 8'hFF;

   localparam logic [7:0] IFS_FN_TEST_REQ = 8'h02;
   localparam logic [7:0] IFS_FN_READ_IN  = 8'h04;
   localparam logic [7:0] IFS_EXC_FUNC    = 8'h01;
   localparam logic [7:0] IFS_EXC_ADDR    = 8'h02;
   localparam logic [7:0] IFS_EXC_QTY     = 8'h03;
   localparam logic [15:0] IFS_QTY_MAX    = 16'h000D;
   localparam logic [15:0] IFS_CRC_INIT   = 16'hFFFF;
   localparam logic [15:0] IFS_CRC_POLY   = 16'hA001;

   // Serial timing
   localparam int IFS_CLK_HZ   = 20000000;
   localparam int IFS_BAUD     = 19200;
   localparam int IFS_BIT_CYC  = IFS_CLK_HZ / IFS_BAUD;
   localparam int IFS_GAP_BITS = 35;
   localparam int IFS_GAP_CYC  = (IFS_BIT_CYC * IFS_GAP_BITS) / 10;
   localparam int IFS_FRAME_MAX = 8;

   typedef struct packed {
      logic [7:0] state;
      logic [7:0] current;
   } ifs_chan_s;

   typedef struct packed {
      logic       valid;
      logic       connected;
      logic       prewarn;
      logic       alarm;
      logic       short_circ;
      logic       faulty;
      logic [7:0] current;
   } ifs_meas_s;

   typedef struct packed {
      logic [7:0] data;
      logic       valid;
   } ifs_byte_s;
endpackage
`default_nettype wire

//--- rtl/ifs_uart_rx.sv
// UART receiver, 8N1, with frame-gap detection.
// Assumes rx_sync is already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
module ifs_uart_rx (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          rx_sync,
   output ifs_pkg::ifs_byte_s rx_byte,
   output logic               gap
);
   logic [15:0] cnt_r;
   logic [3:0]  bit_r;
   logic [7:0]  sh_r;
   logic        busy_r;
   logic [15:0] idle_r;
   logic        mid;

   assign mid = (cnt_r == 16'(ifs_pkg::IFS_BIT_CYC - 1));
   assign gap = (idle_r == 16'(ifs_pkg::IFS_GAP_CYC));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r   <= 16'h0000;
         bit_r   <= 4'h0;
         sh_r    <= 8'h00;
         busy_r  <= 1'b0;
         rx_byte <= '0;
         idle_r  <= 16'h0000;
      end else begin
         rx_byte.valid <= 1'b0;
         if (busy_r || !rx_sync) idle_r <= 16'h0000;
         else if (!gap) idle_r <= idle_r + 16'h0001;
         if (!busy_r) begin
            // Start sampled half a bit in
            cnt_r <= 16'(ifs_pkg::IFS_BIT_CYC / 2);
            bit_r <= 4'h0;
            if (!rx_sync) busy_r <= 1'b1;
         end else if (mid) begin
            cnt_r <= 16'h0000;
            bit_r <= bit_r + 4'h1;
            if (bit_r == 4'h0 && rx_sync) busy_r <= 1'b0;
            else if (bit_r >= 4'h1 && bit_r <= 4'h8) sh_r <= {rx_sync, sh_r[7:1]};
            else if (bit_r == 4'h9) begin
               busy_r <= 1'b0;
               rx_byte.data  <= sh_r;
               rx_byte.valid <= rx_sync;
            end
         end else begin
            cnt_r <= cnt_r + 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

//--- rtl/ifs_uart_tx.sv
// UART transmitter, 8N1, with driver enable for the RS-485 transceiver.
// Assumes one byte offered at a time with a valid/ready handshake.
`timescale 1ns/1ps
`default_nettype none
module ifs_uart_tx (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [7:0] data,
   input  wire logic       valid,
   output logic            ready,
   output logic            txd,
   output logic            tx_oe
);
   logic [15:0] cnt_r;
   logic [3:0]  bit_r;
   logic [9:0]  sh_r;
   logic        busy_r;

   assign ready = !busy_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r  <= 16'h0000;
         bit_r  <= 4'h0;
         sh_r   <= 10'h3FF;
         busy_r <= 1'b0;
         txd    <= 1'b1;
         tx_oe  <= 1'b0;
      end else if (!busy_r) begin
         txd <= 1'b1;
         if (valid) begin
            sh_r   <= {1'b1, data, 1'b0};
            busy_r <= 1'b1;
            tx_oe  <= 1'b1;
            cnt_r  <= 16'h0000;
            bit_r  <= 4'h0;
         end else begin
            tx_oe <= 1'b0;
         end
      end else begin
         txd <= sh_r[0];
         if (cnt_r == 16'(ifs_pkg::IFS_BIT_CYC - 1)) begin
            cnt_r <= 16'h0000;
            sh_r  <= {1'b1, sh_r[9:1]};
            bit_r <= bit_r + 4'h1;
            if (bit_r == 4'h9) busy_r <= 1'b0;
         end else begin
            cnt_r <= cnt_r + 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

//--- rtl/ifs_status_regs.sv
// Insulation fault status bank: read-only input registers served as a Modbus RTU slave.
// Assumes RS-485 transceiver outside; measurement inputs come from logic on clk.
// Behaviour
// - Input registers at fixed addresses; 30001 is protocol address 0, consecutive.
// - Detection state reads 0 when inactive, 1 when done and currents valid.
// - Channel count reads 0x0004 or 0x0008 by variant.
// - Max fault register returns configured maximum current, 1 to 5 mA.
// - Network form: 0 DC, 1 single-phase AC, 2 three-phase AC.
// - Transformer 1 to 4 status at addresses 0x0004 to 0x0007.
// - Transformer 5 to 8 status at addresses 0x0008 to 0x000B.
// - Status upper byte: 0x00 none, 0x01 connected, 0x02 prewarning, 0x04 alarm.
// - Status upper byte 0x10 on short circuit, 0x20 unknown or faulty.
// - Status lower byte holds fault current in 0.1 mA steps.
// - Invalid measurement reports lower byte 0xFF.
// - Event memory upper byte: alarm-occurred bit per channel, bit 0 channel one.
// - Event memory lower byte: prewarning-occurred bit per channel.
`timescale 1ns/1ps
`default_nettype none
module ifs_status_regs (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 rs485_rx,
   output logic                      rs485_tx,
   output logic                      rs485_oe,
   input  wire logic [7:0]           slave_addr,
   input  wire logic                 eight_chan,
   input  wire logic                 detect_done,
   input  wire logic [2:0]           max_fault_ma,
   input  wire logic [1:0]           net_form,
   input  wire ifs_pkg::ifs_meas_s   meas [8],
   input  wire logic                 mem_clear,
   output logic                      test_req,
   output logic [15:0]               event_mem
);
   typedef enum logic [4:0] {
      IFS_IDLE = 5'b00001,
      IFS_RECV = 5'b00010,
      IFS_SKIP = 5'b00100,
      IFS_SEND = 5'b01000,
      IFS_CRCO = 5'b10000
   } ifs_state_e;

   ifs_state_e        st_r;
   logic              rx_m_r;
   logic              rx_s_r;
   ifs_pkg::ifs_byte_s rxb;
   logic              gap;
   logic [7:0]        frm_r [8];
   logic [3:0]        n_r;
   logic [15:0]       crc_r;
   logic [15:0]       crc_in;
   logic [7:0]        crc_byte;
   logic              crc_step;
   logic [15:0]       crc_nxt;
   logic [15:0]       tcrc_r;
   logic [15:0]       tcrc_nxt;
   logic [5:0]        ti_r;
   logic [5:0]        tlen_r;
   logic [7:0]        tb;
   logic              tvalid;
   logic              tready;
   logic [15:0]       start_a;
   logic [15:0]       qty;
   logic              frame_ok;
   logic              for_me;
   logic              bcast;
   logic [7:0]        exc_r;
   logic [7:0]        fn_r;
   logic [15:0]       rd_a_r;
   logic [15:0]       rd_q_r;
   logic [15:0]       rd_word;
   logic [15:0]       rd_idx;
   ifs_pkg::ifs_chan_s chan [8];
   logic [15:0]       mem_r;
   logic [15:0]       mem_set;
   logic [15:0]       chan_code;

   // Pin passes two flops before use
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_m_r <= 1'b1;
         rx_s_r <= 1'b1;
      end else begin
         rx_m_r <= rs485_rx;
         rx_s_r <= rx_m_r;
      end
   end

   ifs_uart_rx u_rx (
      .clk     (clk),
      .rst     (rst),
      .rx_sync (rx_s_r),
      .rx_byte (rxb),
      .gap     (gap)
   );

   ifs_uart_tx u_tx (
      .clk   (clk),
      .rst   (rst),
      .data  (tb),
      .valid (tvalid),
      .ready (tready),
      .txd   (rs485_tx),
      .tx_oe (rs485_oe)
   );

   // Per-channel status words
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : gch
         logic [7:0] stb;
         assign stb = meas[g].faulty     ? ifs_pkg::IFS_ST_UNKNOWN :
                      meas[g].short_circ ? ifs_pkg::IFS_ST_SHORT :
                      !meas[g].connected ? ifs_pkg::IFS_ST_NONE :
                      meas[g].alarm      ? ifs_pkg::IFS_ST_ALARM :
                      meas[g].prewarn    ? ifs_pkg::IFS_ST_PREWARN :
                                           ifs_pkg::IFS_ST_CONN;
         assign chan[g].state   = stb;
         assign chan[g].current = meas[g].valid ? meas[g].current : ifs_pkg::IFS_CUR_INVALID;
         assign mem_set[8 + g]  = meas[g].connected && meas[g].alarm;
         assign mem_set[g]      = meas[g].connected && meas[g].prewarn;
      end
   endgenerate

   // Sticky memory; a new event wins over the clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) mem_r <= 16'h0000;
      else mem_r <= (mem_clear ? 16'h0000 : mem_r) | mem_set;
   end
   assign event_mem = mem_r;

   assign chan_code = eight_chan ? ifs_pkg::IFS_CHAN8_CODE : ifs_pkg::IFS_CHAN4_CODE;

   // Register read mux
   assign rd_idx = rd_a_r;
   always_comb begin
      rd_word = 16'h0000;
      if (rd_idx == ifs_pkg::IFS_REG_DET_STATE) rd_word = {15'h0000, detect_done};
      else if (rd_idx == ifs_pkg::IFS_REG_CHAN_COUNT) rd_word = chan_code;
      else if (rd_idx == ifs_pkg::IFS_REG_MAX_FAULT) rd_word = {13'h0000, max_fault_ma};
      else if (rd_idx == ifs_pkg::IFS_REG_NET_FORM) rd_word = {14'h0000, net_form};
      else if (rd_idx >= ifs_pkg::IFS_REG_CH1_STATUS && rd_idx <= ifs_pkg::IFS_REG_CH8_STATUS)
         rd_word = chan[3'(rd_idx - ifs_pkg::IFS_REG_CH1_STATUS)];
      else if (rd_idx == ifs_pkg::IFS_REG_EVENT_MEM) rd_word = mem_r;
   end

   // CRC-16, one byte per step, reflected polynomial
   assign crc_step = (st_r == IFS_RECV && rxb.valid);
   assign crc_byte = crc_step ? rxb.data : tb;
   assign crc_in   = crc_step ? crc_r : tcrc_r;
   always_comb begin
      crc_nxt = crc_in ^ {8'h00, crc_byte};
      for (int i = 0; i < 8; i++) begin
         crc_nxt = crc_nxt[0] ? ((crc_nxt >> 1) ^ ifs_pkg::IFS_CRC_POLY) : (crc_nxt >> 1);
      end
   end
   assign tcrc_nxt = crc_nxt;

   assign start_a  = {frm_r[2], frm_r[3]};
   assign qty      = {frm_r[4], frm_r[5]};
   assign bcast    = (frm_r[0] == 8'h00);
   assign for_me   = (frm_r[0] == slave_addr) || bcast;
   // Residue of zero over data plus CRC means checksum good
   assign frame_ok = (n_r == 4'h8) && (crc_r == 16'h0000);

   // Response length: addr fn count data.. or addr fn exc
   always_comb begin
      tb = 8'h00;
      if (ti_r == 6'd0) tb = frm_r[0];
      else if (exc_r != 8'h00) begin
         if (ti_r == 6'd1) tb = fn_r | 8'h80;
         else if (ti_r == 6'd2) tb = exc_r;
      end else if (fn_r == ifs_pkg::IFS_FN_TEST_REQ) begin
         if (ti_r == 6'd1) tb = fn_r;
         else if (ti_r == 6'd2) tb = 8'h01;
         else if (ti_r == 6'd3) tb = 8'h01;
      end else begin
         if (ti_r == 6'd1) tb = fn_r;
         else if (ti_r == 6'd2) tb = {rd_q_r[6:0], 1'b0};
         else tb = ti_r[0] ? rd_word[15:8] : rd_word[7:0];
      end
      if (st_r == IFS_CRCO) tb = (ti_r == 6'd0) ? tcrc_r[7:0] : tcrc_r[15:8];
   end
   assign tvalid = (st_r == IFS_SEND) || (st_r == IFS_CRCO);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r     <= IFS_IDLE;
         n_r      <= 4'h0;
         crc_r    <= ifs_pkg::IFS_CRC_INIT;
         tcrc_r   <= ifs_pkg::IFS_CRC_INIT;
         ti_r     <= 6'd0;
         tlen_r   <= 6'd0;
         exc_r    <= 8'h00;
         fn_r     <= 8'h00;
         rd_a_r   <= 16'h0000;
         rd_q_r   <= 16'h0000;
         test_req <= 1'b0;
         for (int i = 0; i < 8; i++) frm_r[i] <= 8'h00;
      end else begin
         test_req <= 1'b0;
         case (st_r)
            IFS_IDLE: begin
               n_r   <= 4'h0;
               crc_r <= ifs_pkg::IFS_CRC_INIT;
               if (gap) st_r <= IFS_RECV;
            end
            IFS_RECV: begin
               if (rxb.valid) begin
                  crc_r <= crc_nxt;
                  if (n_r == 4'(ifs_pkg::IFS_FRAME_MAX)) st_r <= IFS_SKIP;
                  else begin
                     frm_r[3'(n_r)] <= rxb.data;
                     n_r <= n_r + 4'h1;
                  end
               end else if (gap && n_r != 4'h0) begin
                  // Bad CRC or wrong length: drop silently
                  if (frame_ok && for_me) begin
                     fn_r   <= frm_r[1];
                     rd_a_r <= start_a;
                     rd_q_r <= qty;
                     ti_r   <= 6'd0;
                     tcrc_r <= ifs_pkg::IFS_CRC_INIT;
                     exc_r  <= 8'h00;
                     tlen_r <= 6'd3;
                     if (frm_r[1] == ifs_pkg::IFS_FN_TEST_REQ) begin
                        if (start_a != 16'h0000 || qty != 16'h0001) exc_r <= ifs_pkg::IFS_EXC_ADDR;
                        else begin
                           test_req <= 1'b1;
                           tlen_r   <= 6'd4;
                        end
                     end else if (frm_r[1] == ifs_pkg::IFS_FN_READ_IN) begin
                        if (qty == 16'h0000 || qty > ifs_pkg::IFS_QTY_MAX) exc_r <= ifs_pkg::IFS_EXC_QTY;
                        else if (start_a + qty > ifs_pkg::IFS_REG_LAST + 16'h0001)
                           exc_r <= ifs_pkg::IFS_EXC_ADDR;
                        else tlen_r <= 6'(3 + 2 * qty[3:0]);
                     end else begin
                        exc_r <= ifs_pkg::IFS_EXC_FUNC;
                     end
                     // Broadcasts act but never answer
                     st_r <= bcast ? IFS_IDLE : IFS_SEND;
                  end else begin
                     st_r <= IFS_IDLE;
                  end
                  n_r   <= 4'h0;
                  crc_r <= ifs_pkg::IFS_CRC_INIT;
               end
            end
            // Via idle so a stale count and residue never reach the frame check
            IFS_SKIP: if (gap) st_r <= IFS_IDLE;
            IFS_SEND: if (tready) begin
               tcrc_r <= tcrc_nxt;
               if (ti_r >= 6'd3 && !ti_r[0] && fn_r == ifs_pkg::IFS_FN_READ_IN && exc_r == 8'h00)
                  rd_a_r <= rd_a_r + 16'h0001;
               if (ti_r == tlen_r - 6'd1) begin
                  ti_r <= 6'd0;
                  st_r <= IFS_CRCO;
               end else ti_r <= ti_r + 6'd1;
            end
            IFS_CRCO: if (tready) begin
               if (ti_r == 6'd1) begin
                  ti_r <= 6'd0;
                  st_r <= IFS_IDLE;
               end else ti_r <= 6'd1;
            end
            default: st_r <= IFS_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

//--- tb/ifs_status_regs_chk.sv
// Checker: event memory, test request pulse and serial line framing.
// Assumes binding to ifs_status_regs; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module ifs_status_regs_chk (
   input wire logic               clk,
   input wire logic               rst,
   input wire logic               rs485_tx,
   input wire logic               rs485_oe,
   input wire ifs_pkg::ifs_meas_s meas [8],
   input wire logic               mem_clear,
   input wire logic               test_req,
   input wire logic [15:0]        event_mem
);
   logic [7:0]  alm_set;
   logic [7:0]  pre_set;
   logic [15:0] set_v;
   for (genvar g = 0; g < 8; g++) begin : g_set
      assign alm_set[g] = meas[g].connected & meas[g].alarm;
      assign pre_set[g] = meas[g].connected & meas[g].prewarn;
   end
   assign set_v = {alm_set, pre_set};
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // A low bit lasts far longer than eight cycles at this baud
   sequence s_low_bit;
      (!rs485_tx && rs485_oe) [*8];
   endsequence
   AST_ALM_SET: assert property (|alm_set |=> (event_mem[15:8] & $past(alm_set)) == $past(alm_set))
      else $error("alarm bit not stored");
   AST_PRE_SET: assert property (|pre_set |=> (event_mem[7:0] & $past(pre_set)) == $past(pre_set))
      else $error("prewarning bit not stored");
   AST_MEM_HOLD: assert property (($past(event_mem) & ~event_mem) != 16'h0000 |-> $past(mem_clear))
      else $error("event bit lost without clear");
   AST_MEM_RISE: assert property (((event_mem & ~$past(event_mem)) & ~$past(set_v)) == 16'h0000)
      else $error("event bit set without cause");
   AST_MEM_CLR: assert property (mem_clear |=> event_mem == $past(set_v))
      else $error("clear result wrong");
   AST_TEST_PULSE: assert property (test_req |=> !test_req)
      else $error("test request longer than one cycle");
   AST_TEST_QUIET: assert property (test_req |-> !rs485_oe && rs485_tx)
      else $error("test request while transmitting");
   AST_START_BIT: assert property ($fell(rs485_tx) |-> s_low_bit)
      else $error("low bit too short or undriven");
   AST_TX_IDLE: assert property (!rs485_oe |-> rs485_tx)
      else $error("line not idle high while released");
endmodule
bind ifs_status_regs ifs_status_regs_chk chk_u (.clk(clk), .rst(rst), .rs485_tx(rs485_tx), .rs485_oe(rs485_oe),
   .meas(meas), .mem_clear(mem_clear), .test_req(test_req), .event_mem(event_mem));
`default_nettype wire

//--- tb/ifs_master_model.sv
// Partner: bus master sending request frames and collecting replies, 8N1.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module ifs_master_model (
   input  wire logic clk,
   input  wire logic rs485_tx,
   input  wire logic rs485_oe,
   output logic      line_out
);
   localparam int BIT = ifs_pkg::IFS_BIT_CYC;
   logic [7:0] rx_q [$];
   logic       line_in;
   // Released driver leaves the biased line high
   assign line_in = rs485_oe ? rs485_tx : 1'b1;
   // Biased bus idles high
   initial line_out = 1'b1;
   function automatic logic [15:0] crc16(input logic [7:0] q [$]);
      logic [15:0] c;
      c = ifs_pkg::IFS_CRC_INIT;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ ifs_pkg::IFS_CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction
   task automatic put_byte(input logic [7:0] b);
      logic [9:0] sh;
      sh = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_out <= sh[i];
         repeat (BIT) @(posedge clk);
      end
   endtask
   // Request bytes come from the bench; checksum appended low byte first
   task automatic send_frame(input logic [7:0] q [$], input logic bad);
      logic [15:0] c;
      c = crc16(q);
      if (bad) c = c ^ 16'h0001;
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      foreach (q[i]) put_byte(q[i]);
   endtask
   task automatic get_frame(input int n, output logic ok, output logic to);
      int         w;
      logic [7:0] b;
      rx_q.delete();
      ok = 1'b1;
      to = 1'b0;
      for (int k = 0; k < n; k++) begin
         w = 0;
         while (line_in !== 1'b0 && w < 3 * ifs_pkg::IFS_GAP_CYC) begin
            @(posedge clk);
            w++;
         end
         if (w >= 3 * ifs_pkg::IFS_GAP_CYC) begin
            to = 1'b1;
            return;
         end
         repeat (BIT / 2) @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            b[i] = line_in;
         end
         repeat (BIT) @(posedge clk);
         if (line_in !== 1'b1) ok = 1'b0;
         rx_q.push_back(b);
      end
      if (crc16(rx_q[0:n-3]) !== {rx_q[n-1], rx_q[n-2]}) ok = 1'b0;
   endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Testbench: register reads, event memory, test request and a corrupt frame.
// Assumes the package, design, checker and master model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [7:0] SLV = 8'h61;
   logic               clk;
   logic               rst;
   logic               mem_clear;
   ifs_pkg::ifs_meas_s meas [8];
   logic               line_rx;
   logic               rs485_tx;
   logic               rs485_oe;
   logic               test_req;
   logic [15:0]        event_mem;
   logic               eight_chan;
   logic               detect_done;
   logic [2:0]         max_fault_ma;
   logic [1:0]         net_form;
   int                 miscompares;
   int                 check_count;
   always #25 clk = ~clk;
   ifs_status_regs dut_u (.clk(clk), .rst(rst), .rs485_rx(line_rx), .rs485_tx(rs485_tx), .rs485_oe(rs485_oe),
      .slave_addr(SLV), .eight_chan(eight_chan), .detect_done(detect_done), .max_fault_ma(max_fault_ma),
      .net_form(net_form), .meas(meas), .mem_clear(mem_clear), .test_req(test_req),
      .event_mem(event_mem));
   ifs_master_model mst_u (.clk(clk), .rs485_tx(rs485_tx), .rs485_oe(rs485_oe), .line_out(line_rx));
   task automatic print_verdict();
      if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rx(input int n);
      logic ok;
      logic to;
      mst_u.get_frame(n, ok, to);
      if (to) begin
         miscompares++;
         print_verdict();
      end
      chk("reply_ok", 16'h0001, {15'h0000, ok});
   endtask
   function automatic logic [15:0] rd(input int i);
      return {mst_u.rx_q[3+2*i], mst_u.rx_q[4+2*i]};
   endfunction
   task automatic sc_read_all();
      mst_u.send_frame('{SLV, ifs_pkg::IFS_FN_READ_IN, 8'h00, 8'h00, 8'h00, 8'h0D}, 1'b0);
      rx(31);
      chk("hdr", 16'h041A, {mst_u.rx_q[1], mst_u.rx_q[2]});
      chk("det", 16'h0001, rd(0));
      chk("chans", ifs_pkg::IFS_CHAN8_CODE, rd(1));
      chk("maxf", 16'h0005, rd(2));
      chk("net", {14'h0000, ifs_pkg::IFS_NET_3AC}, rd(3));
      chk("ch1", {ifs_pkg::IFS_ST_CONN, 8'h12}, rd(4));
      chk("ch2", {ifs_pkg::IFS_ST_PREWARN, 8'h0B}, rd(5));
      chk("ch3", {ifs_pkg::IFS_ST_ALARM, 8'h33}, rd(6));
      chk("ch4", {ifs_pkg::IFS_ST_SHORT, 8'h05}, rd(7));
      chk("ch5", {ifs_pkg::IFS_ST_UNKNOWN, 8'h07}, rd(8));
      chk("ch6", {ifs_pkg::IFS_ST_NONE, 8'h00}, rd(9));
      chk("ch7", {ifs_pkg::IFS_ST_CONN, ifs_pkg::IFS_CUR_INVALID}, rd(10));
      chk("ch8", {ifs_pkg::IFS_ST_ALARM, 8'h60}, rd(11));
      chk("evmem", 16'h8482, rd(12));
   endtask
   task automatic sc_event_mem();
      mem_clear <= 1'b1;
      @(posedge clk);
      mem_clear <= 1'b0;
      @(negedge clk);
      chk("set_wins", 16'h8482, event_mem);
      @(posedge clk);
      for (int i = 0; i < 8; i++) meas[i] <= meas[i] & 14'h33FF;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("mem_held", 16'h8482, event_mem);
      @(posedge clk);
      mem_clear <= 1'b1;
      @(posedge clk);
      mem_clear <= 1'b0;
      @(negedge clk);
      chk("mem_clr", 16'h0000, event_mem);
      @(posedge clk);
   endtask
   task automatic sc_test();
      int w;
      w = 0;
      // Previous reply must end and the gap pass first
      repeat (ifs_pkg::IFS_GAP_CYC) @(posedge clk);
      mst_u.send_frame('{SLV, ifs_pkg::IFS_FN_TEST_REQ, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0);
      while (test_req !== 1'b1 && w < 2 * ifs_pkg::IFS_GAP_CYC) begin
         @(negedge clk);
         w++;
      end
      chk("test_req", 16'h0001, {15'h0000, test_req});
      if (test_req !== 1'b1) print_verdict();
      rx(6);
      chk("test_rsp", 16'h0201, {mst_u.rx_q[1], mst_u.rx_q[2]});
      chk("test_dat", 16'h0001, {8'h00, mst_u.rx_q[3]});
   endtask
   task automatic sc_bad_crc();
      logic seen;
      seen = 1'b0;
      repeat (ifs_pkg::IFS_GAP_CYC) @(posedge clk);
      mst_u.send_frame('{SLV, ifs_pkg::IFS_FN_TEST_REQ, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b1);
      repeat (2 * ifs_pkg::IFS_GAP_CYC) begin
         @(negedge clk);
         if (test_req !== 1'b0 || rs485_oe !== 1'b0) seen = 1'b1;
      end
      chk("bad_crc_quiet", 16'h0000, {15'h0000, seen});
   endtask
   task automatic sc_variant();
      @(posedge clk);
      eight_chan   <= 1'b0;
      detect_done  <= 1'b0;
      max_fault_ma <= 3'h1;
      net_form     <= ifs_pkg::IFS_NET_DC;
      mst_u.send_frame('{SLV, ifs_pkg::IFS_FN_READ_IN, 8'h00, 8'h00, 8'h00, 8'h04}, 1'b0);
      rx(13);
      chk("det_idle", 16'h0000, rd(0));
      chk("chans4", ifs_pkg::IFS_CHAN4_CODE, rd(1));
      chk("maxf1", 16'h0001, rd(2));
      chk("net_dc", {14'h0000, ifs_pkg::IFS_NET_DC}, rd(3));
   endtask
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      mem_clear = 1'b0;
      miscompares = 0;
      check_count = 0;
      eight_chan = 1'b1;
      detect_done = 1'b1;
      max_fault_ma = 3'h5;
      net_form = ifs_pkg::IFS_NET_3AC;
      // Flag bits: valid, connected, prewarn, alarm, short, faulty
      meas = '{{6'h30, 8'h12}, {6'h38, 8'h0B}, {6'h34, 8'h33}, {6'h22, 8'h05},
               {6'h21, 8'h07}, {6'h20, 8'h00}, {6'h10, 8'h44}, {6'h3C, 8'h60}};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      // Fixed baud makes each frame tens to hundreds of thousands of cycles; kept to four requests and three replies
      repeat (ifs_pkg::IFS_GAP_CYC + 20) @(posedge clk);
      sc_read_all();
      sc_event_mem();
      sc_test();
      sc_bad_crc();
      sc_variant();
      print_verdict();
   end
endmodule
`default_nettype wire
